// *** rtl/port_routing_sync_regs.svh ***
// register offsets, reset values and widths of the port routing block
// assumes: included by the package and by the design modules
`ifndef PORT_ROUTING_SYNC_REGS_SVH
`define PORT_ROUTING_SYNC_REGS_SVH

// widths: 8 data pins, 4 dynamic enable lines, 8-bit register port
`define PRS_PINS       8
`define PRS_OE_LINES   4
`define PRS_ADDR_W     8
`define PRS_DATA_W     8

// register offsets
`define PRS_OFF_PIPE   8'h00
`define PRS_OFF_SYNC   8'h01
`define PRS_OFF_MODE   8'h02
`define PRS_OFF_SRC    8'h03
`define PRS_OFF_STAT   8'h04
`define PRS_OFF_PINS   8'h05
`define PRS_OFF_DRIVE  8'h06

// reset values
`define PRS_RST_PIPE   8'h00
`define PRS_RST_SYNC   8'hFF
`define PRS_RST_MODE   2'h0
`define PRS_RST_SRC    8'h00
`define PRS_RST_STAT   8'h00

// mode field position in the mode register
`define PRS_MODE_LSB   0
`define PRS_MODE_MSB   1

`endif

// *** rtl/port_routing_pkg.sv ***
// types shared by the port routing block and its per-pin path cell
// assumes: the constants header sits beside this file
`include "port_routing_sync_regs.svh"

package port_routing_pkg;

  // per-pin path choice: register stage on output, synchroniser on input
  typedef struct packed {
    logic pipe_en;
    logic sync_en;
  } pin_path_t;

  // how the four dynamic enable lines are spread over the eight pins
  typedef enum logic [1:0] {
    OE_ALL    = 2'h0,
    OE_HALF   = 2'h1,
    OE_PAIR   = 2'h2,
    OE_SINGLE = 2'h3
  } oe_group_t;

endpackage : port_routing_pkg

// *** rtl/pin_path_cell.sv ***
// one pin: optional output register stage, optional two-flop input sync
// assumes: all flops on the system clock; pin input is asynchronous
`timescale 1ns/1ps
`include "port_routing_sync_regs.svh"

module pin_path_cell (
  input  wire logic                       i_core_clk,
  input  wire logic                       i_reset_n,
  input  wire port_routing_pkg::pin_path_t i_path,
  input  wire logic                       i_drive,
  input  wire logic                       i_oe,
  input  wire logic                       i_pin,
  output logic                            o_pin_out,
  output logic                            o_pin_oe_n,
  output logic                            o_route_in,
  output logic                            o_pin_synced
);

  logic out_ff;
  logic oe_ff;
  logic meta_ff;
  logic sync_ff;

  // every stage on the system clock, never a local one
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      out_ff  <= 1'h0;
      oe_ff   <= 1'h0;
      meta_ff <= 1'h0;
      sync_ff <= 1'h0;
    end else begin
      out_ff  <= i_drive;
      oe_ff   <= i_oe;    // enable delayed too so it stays aligned with data
      meta_ff <= i_pin;
      sync_ff <= meta_ff;
    end
  end

  // output: registered or straight through; enable is active low at the pin
  assign o_pin_out  = i_path.pipe_en ? out_ff : i_drive;
  assign o_pin_oe_n = ~(i_path.pipe_en ? oe_ff : i_oe);
  // input stays live while the driver is off; bypass is asynchronous
  assign o_route_in   = i_path.sync_en ? sync_ff : i_pin;
  assign o_pin_synced = sync_ff;

  pipe_delay_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    i_path.pipe_en && $past(i_reset_n) |-> o_pin_out == $past(i_drive))
    else $error("registered output does not follow drive by one cycle");

  direct_out_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    !i_path.pipe_en |-> o_pin_out == i_drive)
    else $error("direct output does not equal drive");

  sync_delay_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    i_path.sync_en && $past(i_reset_n, 2) |-> o_route_in == $past(i_pin, 2))
    else $error("synchronised input is not two cycles late");

  async_pass_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    !i_path.sync_en |-> o_route_in == i_pin)
    else $error("unsynchronised input does not pass through");

  oe_drive_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    !i_path.pipe_en |-> (o_pin_oe_n == !i_oe) && (o_route_in == (i_path.sync_en ?
      o_pin_synced : i_pin)))
    else $error("pin enable or input path wrong");

endmodule : pin_path_cell

// *** rtl/port_routing_sync.sv ***
// port routing block: one 8-bit port joined to the routing fabric
// assumes: register master on i_core_clk, strobes one cycle, never both;
// routing inputs come from logic on the same clock, pins are asynchronous
//
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "port_routing_sync_regs.svh"

module port_routing_sync (
  input  wire logic [`PRS_ADDR_W-1:0]   i_addr,
  input  wire logic                     i_core_clk,
  input  wire logic                     i_reset_n,
  input  wire logic [`PRS_DATA_W-1:0]   i_wr_data,
  input  wire logic                     i_wr_en,
  input  wire logic                     i_rd_en,
  output logic      [`PRS_DATA_W-1:0]   o_rd_data,
  input  wire logic [`PRS_PINS-1:0]     i_route_data_out,
  input  wire logic [`PRS_OE_LINES-1:0] i_route_oe,
  output logic      [`PRS_PINS-1:0]     o_route_data_in,
  input  wire logic [`PRS_PINS-1:0]     i_pin_in,
  output logic      [`PRS_PINS-1:0]     o_pin_out,
  output logic      [`PRS_PINS-1:0]     o_pin_oe_n
);

  // configuration registers
  logic [`PRS_PINS-1:0]            pipe_sel_ff;
  logic [`PRS_PINS-1:0]            sync_sel_ff;
  port_routing_pkg::oe_group_t     oe_mode_ff;
  logic [`PRS_PINS-1:0]            oe_src_ff;
  logic [`PRS_PINS-1:0]            static_oe_ff;
  logic [`PRS_DATA_W-1:0]          rd_data_ff;

  logic [`PRS_PINS-1:0]            nxt_pipe_sel;
  logic [`PRS_PINS-1:0]            nxt_sync_sel;
  port_routing_pkg::oe_group_t     nxt_oe_mode;
  logic [`PRS_PINS-1:0]            nxt_oe_src;
  logic [`PRS_PINS-1:0]            nxt_static_oe;
  logic [`PRS_DATA_W-1:0]          nxt_rd_data;

  // address decode
  logic hit_pipe;
  logic hit_sync;
  logic hit_mode;
  logic hit_src;
  logic hit_stat;
  logic hit_pins;
  logic hit_drive;

  assign hit_pipe  = (i_addr == `PRS_OFF_PIPE);
  assign hit_sync  = (i_addr == `PRS_OFF_SYNC);
  assign hit_mode  = (i_addr == `PRS_OFF_MODE);
  assign hit_src   = (i_addr == `PRS_OFF_SRC);
  assign hit_stat  = (i_addr == `PRS_OFF_STAT);
  assign hit_pins  = (i_addr == `PRS_OFF_PINS);
  assign hit_drive = (i_addr == `PRS_OFF_DRIVE);

  // per-pin state; only pin_sync is seen by the read path
  logic [`PRS_PINS-1:0] pin_sync;   // always the synchronised copy
  logic [`PRS_PINS-1:0] pin_oe;     // enable as chosen, before any stage
  logic [`PRS_PINS-1:0] dyn_oe;     // enable from the dynamic lines

  // next values of the writable registers; a write only lands on a hit
  assign nxt_pipe_sel  = (i_wr_en && hit_pipe) ? i_wr_data : pipe_sel_ff;
  assign nxt_sync_sel  = (i_wr_en && hit_sync) ? i_wr_data : sync_sel_ff;
  assign nxt_oe_src    = (i_wr_en && hit_src)  ? i_wr_data : oe_src_ff;
  assign nxt_static_oe = (i_wr_en && hit_stat) ? i_wr_data : static_oe_ff;
  assign nxt_oe_mode   = (i_wr_en && hit_mode) ?
    port_routing_pkg::oe_group_t'(i_wr_data[`PRS_MODE_MSB:`PRS_MODE_LSB]) :
    oe_mode_ff;

  // read mux; the processor only ever sees synchronised pin levels,
  // so the raw bypass can never leak a metastable bit onto the bus
  assign nxt_rd_data =
    !i_rd_en  ? 8'h00 :
    hit_pipe  ? pipe_sel_ff :
    hit_sync  ? sync_sel_ff :
    hit_mode  ? {6'h00, oe_mode_ff} :
    hit_src   ? oe_src_ff :
    hit_stat  ? static_oe_ff :
    hit_pins  ? pin_sync :
    hit_drive ? ~o_pin_oe_n :
                8'h00;

  // register file; read data stands only in the cycle after the strobe
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pipe_sel_ff  <= `PRS_RST_PIPE;
      sync_sel_ff  <= `PRS_RST_SYNC;
      oe_mode_ff   <= port_routing_pkg::oe_group_t'(`PRS_RST_MODE);
      oe_src_ff    <= `PRS_RST_SRC;
      static_oe_ff <= `PRS_RST_STAT;
      rd_data_ff   <= 8'h00;
    end else begin
      pipe_sel_ff  <= nxt_pipe_sel;
      sync_sel_ff  <= nxt_sync_sel;
      oe_mode_ff   <= nxt_oe_mode;
      oe_src_ff    <= nxt_oe_src;
      static_oe_ff <= nxt_static_oe;
      rd_data_ff   <= nxt_rd_data;
    end
  end

  assign o_rd_data = rd_data_ff;

  // per-pin enable spread and path cells
  // in single mode only pins 0..3 own a line; pins 4..7 then fall back
  // to their static enable, the price of having just four lines
  genvar gi;
  generate
    for (gi = 0; gi < `PRS_PINS; gi++) begin : g_pin
      port_routing_pkg::pin_path_t path;

      // one assignment fills the whole struct, so it has a single driver
      assign path = '{pipe_en: pipe_sel_ff[gi], sync_en: sync_sel_ff[gi]};

      // four lines spread as one gang, two halves, four pairs or singles
      if (gi < `PRS_OE_LINES) begin : g_own
        assign dyn_oe[gi] =
          (oe_mode_ff == port_routing_pkg::OE_ALL)  ? i_route_oe[0] :
          (oe_mode_ff == port_routing_pkg::OE_HALF) ? i_route_oe[gi/4] :
          (oe_mode_ff == port_routing_pkg::OE_PAIR) ? i_route_oe[gi/2] :
                                                      i_route_oe[gi];
        assign pin_oe[gi] = oe_src_ff[gi] ? dyn_oe[gi] : static_oe_ff[gi];
      end else begin : g_shared
        assign dyn_oe[gi] =
          (oe_mode_ff == port_routing_pkg::OE_ALL)  ? i_route_oe[0] :
          (oe_mode_ff == port_routing_pkg::OE_HALF) ? i_route_oe[gi/4] :
          (oe_mode_ff == port_routing_pkg::OE_PAIR) ? i_route_oe[gi/2] :
                                                      static_oe_ff[gi];
        assign pin_oe[gi] = oe_src_ff[gi] ? dyn_oe[gi] : static_oe_ff[gi];
      end

      // routed data joins the chosen enable into one tri-state pin
      pin_path_cell u_cell (
        .i_core_clk   (i_core_clk),
        .i_reset_n    (i_reset_n),
        .i_path       (path),
        .i_drive      (i_route_data_out[gi]),
        .i_oe         (pin_oe[gi]),
        .i_pin        (i_pin_in[gi]),
        .o_pin_out    (o_pin_out[gi]),
        .o_pin_oe_n   (o_pin_oe_n[gi]),
        .o_route_in   (o_route_data_in[gi]),
        .o_pin_synced (pin_sync[gi])
      );
    end
  endgenerate

  // checks
  default clocking cb @(posedge i_core_clk);
  endclocking

  default disable iff (!i_reset_n);

  oe_gang_all_a: assert property (
    (oe_mode_ff == port_routing_pkg::OE_ALL) && (oe_src_ff == 8'hFF) &&
    (pipe_sel_ff == 8'h00) |-> o_pin_oe_n == {8{~i_route_oe[0]}})
    else $error("ganged enable does not reach all eight pins");

  oe_single_a: assert property (
    (oe_mode_ff == port_routing_pkg::OE_SINGLE) && (oe_src_ff == 8'hFF) &&
    (pipe_sel_ff == 8'h00) |-> o_pin_oe_n[3:0] == ~i_route_oe)
    else $error("single enable lines do not map one per pin");

  oe_half_a: assert property (
    (oe_mode_ff == port_routing_pkg::OE_HALF) && (oe_src_ff == 8'hFF) &&
    (pipe_sel_ff == 8'h00) |->
    o_pin_oe_n == {{4{~i_route_oe[1]}}, {4{~i_route_oe[0]}}})
    else $error("half enable grouping wrong");

  oe_static_a: assert property (
    (oe_src_ff == 8'h00) && (pipe_sel_ff == 8'h00) |-> o_pin_oe_n == ~static_oe_ff)
    else $error("static enable does not reach pins");

  direct_port_a: assert property (
    (pipe_sel_ff == 8'h00) && (sync_sel_ff == 8'h00) |->
    (o_pin_out == i_route_data_out) && (o_route_data_in == i_pin_in))
    else $error("direct routed paths broken");

  cpu_sync_read_a: assert property (
    i_rd_en && hit_pins && $past(i_reset_n, 2) |=> o_rd_data == $past(i_pin_in, 3))
    else $error("pin read is not the synchronised level");

  rd_unmapped_a: assert property (
    i_rd_en && (i_addr > `PRS_OFF_DRIVE) |=> o_rd_data == 8'h00)
    else $error("unmapped read is not zero");

  rd_idle_a: assert property (
    !i_rd_en |=> o_rd_data == 8'h00)
    else $error("read data stands outside its cycle");

endmodule : port_routing_sync

// *** bench/fabric_logic_model.sv ***
// routing fabric stand-in: drives the routed data and the four enable lines
// assumes: bench changes the pattern inputs by non-blocking assignment on the clock
`timescale 1ns/1ps

module fabric_logic_model (
  input  wire logic       i_loop,
  input  wire logic [7:0] i_pat_data,
  input  wire logic [3:0] i_pat_oe,
  input  wire logic [7:0] i_route_in,
  output logic      [7:0] o_route_out,
  output logic      [3:0] o_route_oe
);
  // loop mode is plain gates from raw input to output, as fabric logic would be
  assign o_route_out = i_loop ? i_route_in : i_pat_data;
  assign o_route_oe  = i_pat_oe;
endmodule : fabric_logic_model

// *** bench/port_routing_sync_tb.sv ***
// self-checking bench for the port routing block with a fabric stand-in
// assumes: pins driven by the bench; register port master lives here
`timescale 1ns/1ps

module port_routing_sync_tb;
  logic       i_core_clk = 1'h0;
  logic       i_reset_n  = 1'h0;
  logic [7:0] addr       = 8'h00;
  logic [7:0] wdata      = 8'h00;
  logic [7:0] pin_in     = 8'h00;
  logic [7:0] pdat       = 8'h00;
  logic [3:0] poe        = 4'h0;
  logic       wr         = 1'h0;
  logic       rd         = 1'h0;
  logic       loop       = 1'h0;
  logic [7:0] lf         = 8'h3A;
  logic [7:0] rdata, pin_out, oe_n, rin, rout;
  logic [3:0] roe;
  int         n_mismatch = 0;
  int         tests_run  = 0;

  always #10 i_core_clk = ~i_core_clk;

  port_routing_sync uut (
    .i_addr           (addr),
    .i_core_clk       (i_core_clk),
    .i_reset_n        (i_reset_n),
    .i_wr_data        (wdata),
    .i_wr_en          (wr),
    .i_rd_en          (rd),
    .o_rd_data        (rdata),
    .i_route_data_out (rout),
    .i_route_oe       (roe),
    .o_route_data_in  (rin),
    .i_pin_in         (pin_in),
    .o_pin_out        (pin_out),
    .o_pin_oe_n       (oe_n)
  );

  fabric_logic_model fabric (
    .i_loop      (loop),
    .i_pat_data  (pdat),
    .i_pat_oe    (poe),
    .i_route_in  (rin),
    .o_route_out (rout),
    .o_route_oe  (roe)
  );

  // 8-bit maximal sequence, seeded at 58
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  // active-high drive per pin from mode, lines, source select and static bits
  function automatic logic [7:0] oe_exp(input logic [1:0] m, input logic [3:0] l,
                                        input logic [7:0] src, input logic [7:0] st);
    logic d;
    for (int i = 0; i < 8; i++) begin
      case (m)
        2'h0: d = l[0];
        2'h1: d = l[i/4];
        2'h2: d = l[i/2];
        default: d = (i < 4) ? l[i] : st[i];
      endcase
      oe_exp[i] = src[i] ? d : st[i];
    end
  endfunction : oe_exp

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // one-cycle write strobe; the extra edge keeps strobes from colliding
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    wr    <= 1'h1;
    addr  <= a;
    wdata <= d;
    @(posedge i_core_clk);
    wr <= 1'h0;
  endtask : wreg

  // read data is only valid in the cycle after the strobe
  task automatic rreg(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_core_clk);
    rd   <= 1'h1;
    addr <= a;
    @(posedge i_core_clk);
    rd <= 1'h0;
    #1 d = rdata;
  endtask : rreg

  task automatic step(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask : step

  task automatic end_sim();
    $display("mismatches=%0d comparisons=%0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim

  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    #200000;
    n_mismatch++;
    end_sim();
  end

  initial begin
    logic [7:0] v, src, st;
    repeat (16) @(posedge i_core_clk);
    i_reset_n <= 1'h1;
    #1 check(oe_n, 8'hFF);
    // reset values, including the unmapped hole at 07
    for (int a = 0; a < 8; a++) begin
      rreg(8'(a), v);
      check(v, (a == 1) ? 8'hFF : 8'h00);
    end
    // random readback; mode keeps only its two low bits
    for (int a = 0; a < 5; a++) begin
      lf = lfsr(lf);
      wreg(8'(a), lf);
      rreg(8'(a), v);
      check(v, (a == 2) ? {6'h00, lf[1:0]} : lf);
    end
    wreg(8'h00, 8'h00);
    wreg(8'h01, 8'hFF);
    // direct output, then one register stage
    @(posedge i_core_clk);
    pdat <= lf;
    #1 check(pin_out, lf);
    wreg(8'h00, 8'hFF);
    @(posedge i_core_clk);
    pdat <= ~lf;
    #1 check(pin_out, lf);
    step(1);
    check(pin_out, ~lf);
    // two-flop synchroniser, then the processor copy
    @(posedge i_core_clk);
    pin_in <= lf;
    step(1);
    check(rin, 8'h00);
    step(1);
    check(rin, lf);
    rreg(8'h05, v);
    check(v, lf);
    // raw input and feed-through to the pins, no clock involved
    wreg(8'h01, 8'h00);
    wreg(8'h00, 8'h00);
    loop <= 1'h1;
    @(posedge i_core_clk);
    pin_in <= ~lf;
    #1 check(rin, ~lf);
    check(pin_out, ~lf);
    step(3);
    rreg(8'h05, v);
    check(v, ~lf);
    // leave loop mode on a clock edge, like every other fabric input
    @(posedge i_core_clk);
    loop <= 1'h0;
    // every grouping mode with random lines, sources and static bits
    for (int k = 0; k < 12; k++) begin
      src = lfsr(lf);
      st  = lfsr(src);
      lf  = lfsr(st);
      // corner: first pass of each mode sets every pin's source select to dynamic
      if (k < 4) src = 8'hFF;
      wreg(8'h02, {6'h00, 2'(k)});
      wreg(8'h03, src);
      wreg(8'h04, st);
      @(posedge i_core_clk);
      poe <= lf[3:0];
      #1 check(oe_n, ~oe_exp(2'(k), lf[3:0], src, st));
      rreg(8'h06, v);
      check(v, oe_exp(2'(k), lf[3:0], src, st));
    end
    // enable follows the data through the register stage
    wreg(8'h00, 8'hFF);
    wreg(8'h02, 8'h00);
    wreg(8'h03, 8'hFF);
    @(posedge i_core_clk);
    poe <= 4'h0;
    step(2);
    @(posedge i_core_clk);
    poe <= 4'h1;
    #1 check(oe_n, 8'hFF);
    step(1);
    check(oe_n, 8'h00);
    // mid-run reset floats every pin and restores the sync selection
    @(posedge i_core_clk);
    i_reset_n <= 1'h0;
    step(2);
    check(oe_n, 8'hFF);
    @(posedge i_core_clk);
    i_reset_n <= 1'h1;
    rreg(8'h01, v);
    check(v, 8'hFF);
    end_sim();
  end
endmodule : port_routing_sync_tb
